// ==== logic/msf_pkg.sv ====
// Purpose: constants, types and helpers for the mode control and sample FIFO block
// Assumes: 16-bit registers behind an I2C slave, 250 MHz reference clock
// Notes: register offsets are 8-bit I2C register pointers
// Functional notes
// (R1) reset leaves standby, mode register reads zero
// (R2) sample clock off blocks every mode transition
// (R3) code 1 enters program once clock enabled
// (R4) code 2 from program starts normal sampling
// (R5) code 0 returns to standby
// (R6) clock cleared outside standby locks mode forever
// (R7) host clears sample clock only in standby
// (R8) 0x00FF clears flags, 0x80FF also flushes; code flushes only while access bit 0 is set
// (R9) 128-byte FIFO, per-slot format field selects data
// (R10) both slots only with equal averaging factors
// (R11) one packet per output period, all slots
// (R12) channel data 16 or 32 bits, 2-16 bytes
// (R13) packet stored only when wholly fits, else dropped
// (R14) host reads whole packets only
// (R15) status upper byte shows fill in bytes
// (R16) threshold field sets FIFO interrupt level
// (R17) mask bit 8 gates FIFO interrupt
// (R18) pin config register shapes interrupt pin
// (R19) host enables access by two writes, then clears
// (R20) data port reads pop words, freeing space
// (R21) FIFO interrupt clears itself below threshold
// (R22) each LED control holds 3-bit slew field
// (R23) status bit 15 with access enabled flushes
// (R24) 32 kHz clock paces sample and mode timing
// (R25) locked data port reads never pop
package msf_pkg;
	localparam int REF_CLK_HZ     = 250_000_000;
	localparam int SAMPLE_CLK_HZ  = 32_000;
	localparam int SAMPLE_DIV_DEF = REF_CLK_HZ / SAMPLE_CLK_HZ;
	localparam int DIV_W          = 13;

	localparam logic [7:0] REG_STATUS    = 8'h00;
	localparam logic [7:0] REG_INT_MASK  = 8'h01;
	localparam logic [7:0] REG_INT_PIN   = 8'h02;
	localparam logic [7:0] REG_FIFO_THR  = 8'h06;
	localparam logic [7:0] REG_MODE      = 8'h10;
	localparam logic [7:0] REG_SLOT_CFG  = 8'h11;
	localparam logic [7:0] REG_LED1      = 8'h22;
	localparam logic [7:0] REG_LED2      = 8'h23;
	localparam logic [7:0] REG_LED3      = 8'h24;
	localparam logic [7:0] REG_CLK_CTRL  = 8'h4B;
	localparam logic [7:0] REG_ACCESS    = 8'h5F;
	localparam logic [7:0] REG_FIFO_DATA = 8'h60;

	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_PROGRAM = 2'h1;
	localparam logic [1:0] MODE_NORMAL  = 2'h2;

	localparam int CLK_EN_BIT    = 7;
	localparam int ACC_EN_BIT    = 0;
	localparam int FLUSH_BIT     = 15;
	localparam int FIFO_MASK_BIT = 8;
	localparam int SLOT_A_BIT    = 5;
	localparam int SLOT_B_BIT    = 6;
	localparam int THR_HI        = 13;
	localparam int THR_LO        = 8;
	localparam int SLEW_HI       = 6;
	localparam int SLEW_LO       = 4;
	localparam int PIN_POL_BIT   = 0;
	localparam int PIN_DRV_BIT   = 1;
	localparam int FMT_A_LO      = 0;
	localparam int FMT_B_LO      = 4;
	localparam int FMT_W         = 3;

	localparam logic [15:0] MASK_RESET = 16'hFFFF;
	localparam logic [15:0] REG_ZERO   = 16'h0000;

	localparam int FIFO_BYTES  = 128;
	localparam int WORD_BYTES  = 2;
	localparam int FIFO_WORDS  = FIFO_BYTES / WORD_BYTES;
	localparam int IDX_W       = 6;
	localparam int CNT_W       = 7;
	localparam int PKT_W       = 5;
	localparam int DATA_W      = 16;
	localparam int STAGE_DEPTH = 8;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [1:0] {MS_STANDBY = 2'b00, MS_PROGRAM = 2'b01, MS_NORMAL = 2'b11} msf_mode_e;
	typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_STORE = 2'b01, WR_DROP = 2'b11} msf_wr_e;
	typedef enum logic [2:0] {
		I2_IDLE  = 3'b000,
		I2_ADDR  = 3'b001,
		I2_REG   = 3'b011,
		I2_WDATA = 3'b010,
		I2_RDATA = 3'b110
	} msf_i2c_e;

	// words one slot adds to a packet: none, then 2, 4, 8 or 16 bytes
	function automatic logic [PKT_W-1:0] slot_words(input logic [FMT_W-1:0] fmt);
		unique case (fmt)
			3'h1:    slot_words = 5'h01;
			3'h2:    slot_words = 5'h02;
			3'h3:    slot_words = 5'h04;
			3'h4:    slot_words = 5'h08;
			default: slot_words = 5'h00;
		endcase
	endfunction

	function automatic logic [1:0] mode_code(input msf_mode_e m);
		unique case (m)
			MS_STANDBY: mode_code = MODE_STANDBY;
			MS_PROGRAM: mode_code = MODE_PROGRAM;
			MS_NORMAL:  mode_code = MODE_NORMAL;
		endcase
	endfunction
endpackage

// ==== logic/msf_top.sv ====
// Purpose: mode state machine, packet FIFO and I2C register slave
// Assumes: scl/sda from pins, sample words from the slot engine on ref_clk_i
// Notes: depth of the staging FIFO must be a power of two
`timescale 1ns/1ps
module msf_stage_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,        // clock
	input  wire logic             rst_i,        // sync reset
	input  wire logic             in_valid_i,   // source word valid
	input  wire logic [WIDTH-1:0] in_data_i,    // source word
	output logic                  in_ready_o,   // space left
	output logic                  out_valid_o,  // word waiting
	output logic      [WIDTH-1:0] out_data_o,   // head word
	input  wire logic             out_ready_i   // drain takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign in_ready_o  = cnt_r != DEPTH[AW:0];
	assign out_valid_o = cnt_r != '0;
	assign out_data_o  = mem_r[rp_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
		if (push)
			mem_r[wp_r] <= in_data_i;

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
endmodule

module msf_top #(
	parameter int         SAMPLE_DIV = msf_pkg::SAMPLE_DIV_DEF,
	parameter logic [6:0] SLAVE_ADDR = 7'h2A  // arbitrary value
) (
	input  wire logic        ref_clk_i,              // 250 MHz clock
	input  wire logic        rst_i,                  // sync reset, high
	input  wire logic        scl_i,                  // I2C clock pin
	input  wire logic        sda_i,                  // I2C data pin level
	output logic             sda_o,                  // I2C data drive value
	output logic             sda_oe_o,               // high pulls sda low
	input  wire logic        sample_valid_i,         // slot word valid
	input  wire logic [15:0] sample_data_i,          // slot word
	output logic             sample_ready_o,         // slot word taken
	input  wire logic        slot_a_done_i,          // slot A data updated
	input  wire logic        slot_b_done_i,          // slot B data updated
	output logic             int_o,                  // interrupt pin value
	output logic             int_oe_o,               // interrupt pin drive
	output logic [1:0]       mode_o,                 // current mode code
	output logic             sample_clock_enable_o,  // 32 kHz clock on
	output logic             fifo_read_enable_o,     // FIFO reads allowed
	output logic [2:0]       led1_slew_o,            // LED driver 1 slew
	output logic [2:0]       led2_slew_o,            // LED driver 2 slew
	output logic [2:0]       led3_slew_o             // LED driver 3 slew
);
	localparam int PW = msf_pkg::PKT_W;
	localparam int CW = msf_pkg::CNT_W;

	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic       scl_f_r;
	logic       sda_f_r;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;

	msf_pkg::msf_i2c_e st_r;
	logic        ack_r;
	logic        mack_r;
	logic [3:0]  bitcnt_r;
	logic [7:0]  rx_r;
	logic [7:0]  hi_r;
	logic [7:0]  reg_ptr_r;
	logic        byte_lo_r;
	logic        rd_lo_r;
	logic [15:0] tx_r;
	logic [15:0] tx_src;
	logic        wr_stb_r;
	logic [15:0] wr_data_r;
	logic        pop_r;
	logic [15:0] rd_word;
	logic        sda_oe_r;

	logic [15:0] int_mask_r;
	logic [15:0] int_pin_r;
	logic [5:0]  thr_r;
	logic [15:0] slot_cfg_r;
	logic [2:0]  slew_r [3];
	logic [7:0]  clk_ctrl_r;
	logic [2:0]  access_r;
	logic [1:0]  mode_req_r;
	logic        acc_prev_r;
	logic        fifo_read_enable_r;
	logic        flag_a_r;
	logic        flag_b_r;
	logic        int_r;

	msf_pkg::msf_mode_e mode_r;
	logic                stuck_r;
	logic [msf_pkg::DIV_W-1:0] div_r;
	logic                tick;

	logic [15:0] mem_r [msf_pkg::FIFO_WORDS];
	logic [msf_pkg::IDX_W-1:0] wr_idx_r;
	logic [msf_pkg::IDX_W-1:0] rd_idx_r;
	logic [CW-1:0] count_r;
	logic [CW-1:0] free_words;
	logic [PW-1:0] pkt_words;
	logic [PW-1:0] left_r;
	msf_pkg::msf_wr_e wr_st_r;
	logic        st_valid;
	logic [15:0] st_data;
	logic        st_ready;
	logic        wr_en;
	logic        pop_ok;
	logic        flush;
	logic        fifo_irq;
	logic        clk_en;
	logic        wr_status;

	// pin sampling: a change counts once the second and third stages agree
	always_ff @(posedge ref_clk_i)
		if (rst_i)
		begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
		end
		else
		begin
			scl_s_r <= {scl_s_r[1:0], scl_i};
			sda_s_r <= {sda_s_r[1:0], sda_i};
			if (scl_s_r[1] == scl_s_r[2])
				scl_f_r <= scl_s_r[2];
			if (sda_s_r[1] == sda_s_r[2])
				sda_f_r <= sda_s_r[2];
		end

	assign scl_rise  = (scl_s_r[1] == scl_s_r[2]) && scl_s_r[2] && !scl_f_r;
	assign scl_fall  = (scl_s_r[1] == scl_s_r[2]) && !scl_s_r[2] && scl_f_r;
	assign start_det = (sda_s_r[1] == sda_s_r[2]) && !sda_s_r[2] && sda_f_r && scl_f_r;
	assign stop_det  = (sda_s_r[1] == sda_s_r[2]) && sda_s_r[2] && !sda_f_r && scl_f_r;
	assign tx_src    = rd_lo_r ? tx_r : rd_word;
	assign sda_o     = 1'b0;
	assign sda_oe_o  = sda_oe_r;

	// register view; data port reads zero while locked
	always_comb
	begin
		rd_word = msf_pkg::REG_ZERO;
		unique case (reg_ptr_r)
			msf_pkg::REG_STATUS:    rd_word = {count_r, 1'b0, 1'b0, flag_b_r, flag_a_r, 5'h00};  // see (R15)
			msf_pkg::REG_INT_MASK:  rd_word = int_mask_r;
			msf_pkg::REG_INT_PIN:   rd_word = int_pin_r;
			msf_pkg::REG_FIFO_THR:  rd_word = {2'h0, thr_r, 8'h00};
			msf_pkg::REG_MODE:      rd_word = {14'h0000, msf_pkg::mode_code(mode_r)};
			msf_pkg::REG_SLOT_CFG:  rd_word = slot_cfg_r;
			msf_pkg::REG_LED1:      rd_word = {9'h000, slew_r[0], 4'h0};
			msf_pkg::REG_LED2:      rd_word = {9'h000, slew_r[1], 4'h0};
			msf_pkg::REG_LED3:      rd_word = {9'h000, slew_r[2], 4'h0};
			msf_pkg::REG_CLK_CTRL:  rd_word = {8'h00, clk_ctrl_r};
			msf_pkg::REG_ACCESS:    rd_word = {13'h0000, access_r};
			msf_pkg::REG_FIFO_DATA: rd_word = fifo_read_enable_r ? mem_r[rd_idx_r] : msf_pkg::REG_ZERO;
			default:                rd_word = msf_pkg::REG_ZERO;
		endcase
	end

	// byte engine: pointer byte, then 16-bit words high byte first, pointer does not advance
	always_ff @(posedge ref_clk_i)
		if (rst_i)
		begin
			st_r      <= msf_pkg::I2_IDLE;
			ack_r     <= 1'b0;
			mack_r    <= 1'b0;
			bitcnt_r  <= 4'h0;
			rx_r      <= 8'h00;
			hi_r      <= 8'h00;
			reg_ptr_r <= 8'h00;
			byte_lo_r <= 1'b0;
			rd_lo_r   <= 1'b0;
			tx_r      <= 16'h0000;
			sda_oe_r  <= 1'b0;
			wr_stb_r  <= 1'b0;
			wr_data_r <= 16'h0000;
			pop_r     <= 1'b0;
		end
		else
		begin
			wr_stb_r <= 1'b0;
			pop_r    <= 1'b0;
			if (start_det)
			begin
				st_r     <= msf_pkg::I2_ADDR;
				ack_r    <= 1'b0;
				bitcnt_r <= 4'h0;
				rd_lo_r  <= 1'b0;
				sda_oe_r <= 1'b0;
			end
			else if (stop_det)
			begin
				st_r     <= msf_pkg::I2_IDLE;
				ack_r    <= 1'b0;
				sda_oe_r <= 1'b0;
			end
			else if (scl_rise && st_r != msf_pkg::I2_IDLE)
			begin
				if (ack_r)
					mack_r <= sda_f_r;
				else
				begin
					bitcnt_r <= bitcnt_r + 1'b1;
					rx_r     <= {rx_r[6:0], sda_f_r};
				end
			end
			else if (scl_fall && st_r != msf_pkg::I2_IDLE)
			begin
				if (!ack_r && bitcnt_r == msf_pkg::BITS_PER_BYTE)
				begin
					bitcnt_r <= 4'h0;
					sda_oe_r <= 1'b0;
					ack_r    <= 1'b1;
					if (st_r == msf_pkg::I2_ADDR && rx_r[7:1] == SLAVE_ADDR)
						sda_oe_r <= 1'b1;
					else if (st_r == msf_pkg::I2_ADDR)
						st_r <= msf_pkg::I2_IDLE;
					else if (st_r == msf_pkg::I2_REG)
					begin
						reg_ptr_r <= rx_r;
						sda_oe_r  <= 1'b1;
					end
					else if (st_r == msf_pkg::I2_WDATA)
					begin
						sda_oe_r  <= 1'b1;
						byte_lo_r <= !byte_lo_r;
						if (byte_lo_r)
						begin
							wr_stb_r  <= 1'b1;
							wr_data_r <= {hi_r, rx_r};
						end
						else
							hi_r <= rx_r;
					end
				end
				else if (ack_r)
				begin
					ack_r    <= 1'b0;
					sda_oe_r <= 1'b0;
					if ((st_r == msf_pkg::I2_ADDR && rx_r[0]) || (st_r == msf_pkg::I2_RDATA && !mack_r))
					begin
						st_r     <= msf_pkg::I2_RDATA;
						sda_oe_r <= !tx_src[15];
						tx_r     <= {tx_src[14:0], 1'b0};
						rd_lo_r  <= !rd_lo_r;
						if (!rd_lo_r && reg_ptr_r == msf_pkg::REG_FIFO_DATA && fifo_read_enable_r)
							pop_r <= 1'b1;  // see (R20) (R25)
					end
					else if (st_r == msf_pkg::I2_ADDR)
						st_r <= msf_pkg::I2_REG;
					else if (st_r == msf_pkg::I2_REG)
					begin
						st_r      <= msf_pkg::I2_WDATA;
						byte_lo_r <= 1'b0;
					end
					else if (st_r == msf_pkg::I2_RDATA)
						st_r <= msf_pkg::I2_IDLE;
				end
				else if (st_r == msf_pkg::I2_RDATA)
				begin
					sda_oe_r <= !tx_r[15];
					tx_r     <= {tx_r[14:0], 1'b0};
				end
			end
		end

	function automatic logic wr_hit(input logic [7:0] addr);
		wr_hit = wr_stb_r && reg_ptr_r == addr;
	endfunction

	assign clk_en    = clk_ctrl_r[msf_pkg::CLK_EN_BIT];
	assign wr_status = wr_hit(msf_pkg::REG_STATUS);
	assign flush     = wr_status && wr_data_r[msf_pkg::FLUSH_BIT] && access_r[msf_pkg::ACC_EN_BIT];  // see (R8) (R23)

	always_ff @(posedge ref_clk_i)
		if (rst_i)
		begin
			int_mask_r <= msf_pkg::MASK_RESET;
			int_pin_r  <= msf_pkg::REG_ZERO;
			thr_r      <= 6'h00;
			slot_cfg_r <= msf_pkg::REG_ZERO;
			slew_r     <= '{3'h0, 3'h0, 3'h0};
			clk_ctrl_r <= 8'h00;
			access_r   <= 3'h0;
			mode_req_r <= msf_pkg::MODE_STANDBY;
		end
		else
		begin
			if (wr_hit(msf_pkg::REG_INT_MASK))
				int_mask_r <= wr_data_r;
			if (wr_hit(msf_pkg::REG_INT_PIN))
				int_pin_r <= wr_data_r;
			if (wr_hit(msf_pkg::REG_FIFO_THR))
				thr_r <= wr_data_r[msf_pkg::THR_HI:msf_pkg::THR_LO];
			if (wr_hit(msf_pkg::REG_SLOT_CFG))
				slot_cfg_r <= wr_data_r;
			if (wr_hit(msf_pkg::REG_LED1))
				slew_r[0] <= wr_data_r[msf_pkg::SLEW_HI:msf_pkg::SLEW_LO];  // see (R22)
			if (wr_hit(msf_pkg::REG_LED2))
				slew_r[1] <= wr_data_r[msf_pkg::SLEW_HI:msf_pkg::SLEW_LO];  // see (R22)
			if (wr_hit(msf_pkg::REG_LED3))
				slew_r[2] <= wr_data_r[msf_pkg::SLEW_HI:msf_pkg::SLEW_LO];  // see (R22)
			if (wr_hit(msf_pkg::REG_CLK_CTRL))
				clk_ctrl_r <= wr_data_r[7:0];
			if (wr_hit(msf_pkg::REG_ACCESS))
				access_r <= wr_data_r[2:0];
			if (wr_hit(msf_pkg::REG_MODE))
				mode_req_r <= wr_data_r[1:0];
		end

	// reads open only after two back-to-back writes of one; a single stray write cannot unlock
	always_ff @(posedge ref_clk_i)
		if (rst_i)
		begin
			acc_prev_r         <= 1'b0;
			fifo_read_enable_r <= 1'b0;
		end
		else if (wr_stb_r)
		begin
			acc_prev_r <= wr_hit(msf_pkg::REG_ACCESS) && wr_data_r[msf_pkg::ACC_EN_BIT];
			if (wr_hit(msf_pkg::REG_ACCESS) && !wr_data_r[msf_pkg::ACC_EN_BIT])
				fifo_read_enable_r <= 1'b0;
			else if (wr_hit(msf_pkg::REG_ACCESS) && acc_prev_r)
				fifo_read_enable_r <= 1'b1;
		end

	// sample clock tick; mode changes are taken only on it
	always_ff @(posedge ref_clk_i)
		if (rst_i || !clk_en)
			div_r <= '0;
		else if (tick)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	assign tick = clk_en && div_r == msf_pkg::DIV_W'(SAMPLE_DIV - 1);  // see (R24)

	always_ff @(posedge ref_clk_i)
		if (rst_i)
		begin
			mode_r  <= msf_pkg::MS_STANDBY;  // see (R1)
			stuck_r <= 1'b0;
		end
		else
		begin
			if (wr_hit(msf_pkg::REG_CLK_CTRL) && !wr_data_r[msf_pkg::CLK_EN_BIT]
				&& mode_r != msf_pkg::MS_STANDBY)
				stuck_r <= 1'b1;  // see (R6) (R7)
			if (tick && !stuck_r)  // see (R2) (R6)
			begin
				if (mode_req_r == msf_pkg::MODE_PROGRAM)
					mode_r <= msf_pkg::MS_PROGRAM;  // see (R3)
				else if (mode_req_r == msf_pkg::MODE_NORMAL && mode_r == msf_pkg::MS_PROGRAM)
					mode_r <= msf_pkg::MS_NORMAL;  // see (R4)
				else if (mode_req_r == msf_pkg::MODE_STANDBY)
					mode_r <= msf_pkg::MS_STANDBY;  // see (R5)
			end
		end

	msf_stage_fifo #(
		.WIDTH (msf_pkg::DATA_W),
		.DEPTH (msf_pkg::STAGE_DEPTH)
	) u_stage (
		.clk_i       (ref_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (sample_valid_i),
		.in_data_i   (sample_data_i),
		.in_ready_o  (sample_ready_o),
		.out_valid_o (st_valid),
		.out_data_o  (st_data),
		.out_ready_i (st_ready)
	);

	assign pkt_words  = msf_pkg::slot_words(slot_cfg_r[msf_pkg::FMT_A_LO +: msf_pkg::FMT_W])
		+ msf_pkg::slot_words(slot_cfg_r[msf_pkg::FMT_B_LO +: msf_pkg::FMT_W]);  // see (R9) (R12)
	assign free_words = CW'(msf_pkg::FIFO_WORDS) - count_r;
	// idle stalls the stage one cycle per packet while the fit is decided
	assign st_ready   = wr_st_r != msf_pkg::WR_IDLE
		|| mode_r != msf_pkg::MS_NORMAL || pkt_words == '0;
	assign wr_en      = st_valid && wr_st_r == msf_pkg::WR_STORE && !flush;
	assign pop_ok     = pop_r && count_r != '0;

	// packets arrive as pkt_words consecutive words, one packet per output period
	always_ff @(posedge ref_clk_i)
		if (rst_i)
		begin
			wr_st_r <= msf_pkg::WR_IDLE;
			left_r  <= '0;
		end
		else
			unique case (wr_st_r)
				msf_pkg::WR_IDLE:
					if (st_valid && mode_r == msf_pkg::MS_NORMAL && pkt_words != '0)
					begin
						left_r <= pkt_words;  // see (R11)
						if (free_words >= CW'(pkt_words))
							wr_st_r <= msf_pkg::WR_STORE;  // see (R13)
						else
							wr_st_r <= msf_pkg::WR_DROP;  // see (R13)
					end
				msf_pkg::WR_STORE, msf_pkg::WR_DROP:
					if (st_valid)
					begin
						left_r <= left_r - 1'b1;
						if (left_r == PW'(1))
							wr_st_r <= msf_pkg::WR_IDLE;
						else if (flush)
							wr_st_r <= msf_pkg::WR_DROP;
					end
					else if (flush)
						wr_st_r <= msf_pkg::WR_DROP;
			endcase

	always_ff @(posedge ref_clk_i)
		if (wr_en)
			mem_r[wr_idx_r] <= st_data;

	always_ff @(posedge ref_clk_i)
		if (rst_i || flush)
		begin
			wr_idx_r <= '0;
			rd_idx_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (wr_en)
				wr_idx_r <= wr_idx_r + 1'b1;
			if (pop_ok)
				rd_idx_r <= rd_idx_r + 1'b1;  // see (R20)
			count_r <= count_r + CW'(wr_en) - CW'(pop_ok);
		end

	// slot flags: hardware set beats software clear in the same cycle
	always_ff @(posedge ref_clk_i)
		if (rst_i)
		begin
			flag_a_r <= 1'b0;
			flag_b_r <= 1'b0;
		end
		else
		begin
			flag_a_r <= slot_a_done_i || (flag_a_r && !(wr_status && wr_data_r[msf_pkg::SLOT_A_BIT]));  // see (R8)
			flag_b_r <= slot_b_done_i || (flag_b_r && !(wr_status && wr_data_r[msf_pkg::SLOT_B_BIT]));  // see (R8)
		end

	assign fifo_irq = count_r > CW'(thr_r);  // see (R16) (R21)

	always_ff @(posedge ref_clk_i)
		if (rst_i)
			int_r <= 1'b0;
		else
			int_r <= ((fifo_irq && !int_mask_r[msf_pkg::FIFO_MASK_BIT])  // see (R17)
				|| (flag_a_r && !int_mask_r[msf_pkg::SLOT_A_BIT])
				|| (flag_b_r && !int_mask_r[msf_pkg::SLOT_B_BIT])) ^ int_pin_r[msf_pkg::PIN_POL_BIT];

	assign int_o                 = int_r;  // see (R18)
	assign int_oe_o              = int_pin_r[msf_pkg::PIN_DRV_BIT];  // see (R18)
	assign mode_o                = msf_pkg::mode_code(mode_r);
	assign sample_clock_enable_o = clk_en;
	assign fifo_read_enable_o    = fifo_read_enable_r;
	assign led1_slew_o           = slew_r[0];
	assign led2_slew_o           = slew_r[1];
	assign led3_slew_o           = slew_r[2];

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	reset_standby_a: assert property ($fell(rst_i) |-> mode_r == msf_pkg::MS_STANDBY && !stuck_r)  // see (R1)
		else $error("mode not standby after reset");
	gated_mode_a: assert property (!clk_en |=> $stable(mode_r))  // see (R2)
		else $error("mode moved with sample clock off");
	program_entry_a: assert property (tick && !stuck_r && mode_req_r == msf_pkg::MODE_PROGRAM
		|=> mode_r == msf_pkg::MS_PROGRAM)  // see (R3)
		else $error("program mode not entered");
	normal_entry_a: assert property (tick && !stuck_r && mode_req_r == msf_pkg::MODE_NORMAL
		&& mode_r == msf_pkg::MS_PROGRAM |=> mode_r == msf_pkg::MS_NORMAL)  // see (R4)
		else $error("normal mode not entered");
	standby_entry_a: assert property (tick && !stuck_r && mode_req_r == msf_pkg::MODE_STANDBY
		|=> mode_r == msf_pkg::MS_STANDBY)  // see (R5)
		else $error("standby not entered");
	stuck_hold_a: assert property (stuck_r |=> stuck_r && $stable(mode_r))  // see (R6)
		else $error("locked mode changed");
	flush_empty_a: assert property (flush |=> count_r == '0 ##1 count_r <= CW'(1))  // see (R8)
		else $error("flush left data");
	level_report_a: assert property (reg_ptr_r == msf_pkg::REG_STATUS |-> rd_word[15:8] == {count_r, 1'b0})  // see (R15)
		else $error("status level wrong");
	whole_packet_a: assert property (wr_st_r == msf_pkg::WR_IDLE ##1 wr_st_r == msf_pkg::WR_STORE
		|-> $past(free_words) >= CW'($past(pkt_words)))  // see (R13)
		else $error("packet stored without room");
	irq_level_a: assert property (!int_mask_r[msf_pkg::FIFO_MASK_BIT] && !int_pin_r[msf_pkg::PIN_POL_BIT]
		&& fifo_irq && $stable(int_mask_r) && $stable(int_pin_r) |=> int_r)  // see (R16) (R17)
		else $error("fifo interrupt missing");
	locked_read_a: assert property (!fifo_read_enable_r && !wr_en && !flush |=> count_r == $past(count_r))  // see (R25)
		else $error("locked read changed level");
	depth_bound_a: assert property (count_r <= CW'(msf_pkg::FIFO_WORDS))  // see (R9)
		else $error("fifo overfilled");
endmodule

// ==== tb/msf_host.sv ====
// Purpose: I2C host model for the register bus
// Assumes: open-drain sda pulled up by the bench
// Notes: 8 ref cycles per quarter bit
`timescale 1ns/1ps
module msf_host (
	input  wire logic clk_i,    // ref clock
	input  wire logic sda_i,    // bus level
	output logic      scl_o,    // bus clock
	output logic      sda_oe_o  // high pulls sda low
);
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic q();
		repeat (8) @(posedge clk_i);
	endtask
	task automatic bx(input logic b, output logic r);
		sda_oe_o <= !b;
		q();
		scl_o <= 1'b1;
		q();
		q();
		r = sda_i;
		scl_o <= 1'b0;
		q();
	endtask
	task automatic by(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bx(d[i], r[i]);
	endtask
	task automatic start();
		sda_oe_o <= 1'b0;
		q();
		scl_o <= 1'b1;
		q();
		sda_oe_o <= 1'b1;
		q();
		scl_o <= 1'b0;
		q();
	endtask
	task automatic send(input logic [7:0] d);
		logic [7:0] r;
		logic a;
		by(d, r);
		bx(1'b1, a);
	endtask
	task automatic stop();
		sda_oe_o <= 1'b1;
		q();
		scl_o <= 1'b1;
		q();
		sda_oe_o <= 1'b0;
		q();
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		start();
		send(8'h54);
		send(a);
		send(d[15:8]);
		send(d[7:0]);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		logic k;
		start();
		send(8'h54);
		send(a);
		start();
		send(8'h55);
		by(8'hFF, d[15:8]);
		bx(1'b0, k);
		by(8'hFF, d[7:0]);
		bx(1'b1, k);
		stop();
	endtask
endmodule

// ==== tb/msf_top_tb_top.sv ====
// Purpose: self-checking bench for msf_top
// Assumes: SAMPLE_DIV cut to 16
// Notes: FIFO mirrored in a queue
`timescale 1ns/1ps
module msf_top_tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl, h_oe, sda_oe, int_o, rdy, sv = 1'b0;
	logic [15:0] sd = 16'h0000, rv, a, b, xs = 16'h4193;
	logic [1:0] mode;
	logic fre, sce, ioe;
	logic [2:0] s1, s2, s3;
	wire sda = !(h_oe | sda_oe);
	int n_errors = 0, tests_run = 0, cyc = 0;
	logic [15:0] q[$];
	always #2 ref_clk_i = !ref_clk_i;
	msf_top #(.SAMPLE_DIV(16)) i_msf_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .sample_valid_i(sv),
		.sample_data_i(sd), .sample_ready_o(rdy), .slot_a_done_i(1'b0),
		.slot_b_done_i(1'b0), .int_o(int_o), .int_oe_o(ioe), .mode_o(mode),
		.sample_clock_enable_o(sce), .fifo_read_enable_o(fre), .led1_slew_o(s1),
		.led2_slew_o(s2), .led3_slew_o(s3));
	msf_host i_msf_host (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
	task automatic chk(input logic [15:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			n_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_errors++;
			close_out();
		end
	end
	function automatic logic [15:0] xr();
		xs ^= xs << 7;
		xs ^= xs >> 9;
		xs ^= xs << 8;
		return xs;
	endfunction
	// mode changes land on the next sample tick, 16 cycles at most
	task automatic w(input logic [7:0] ad, input logic [15:0] d);
		i_msf_host.wr(ad, d);
		repeat (40) @(posedge ref_clk_i);
	endtask
	task automatic push(input logic [15:0] d);
		sv <= 1'b1;
		sd <= d;
		do @(negedge ref_clk_i); while (rdy !== 1'b1);
		@(posedge ref_clk_i);
	endtask
	task automatic st();
		i_msf_host.rd(8'h00, rv);
		chk(rv & 16'hFF00, 16'(q.size() * 2) << 8);
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		chk(16'(mode), 16'h0000);
		i_msf_host.rd(8'h01, rv);
		chk(rv, 16'hFFFF);
		w(8'h10, 16'h0001);
		chk(16'(mode), 16'h0000);
		w(8'h4B, 16'h0080);
		chk(16'(mode), 16'h0001);
		chk(16'(sce), 16'h0001);
		for (int k = 0; k < 3; k++)
			w(8'h22 + 8'(k), 16'h0050 + 16'(k * 16));
		chk({7'h00, s1, s2, s3}, 16'h0177);
		w(8'h11, 16'h0002);
		w(8'h06, 16'h0100);
		w(8'h01, 16'hFEFF);
		w(8'h10, 16'h0002);
		chk(16'(mode), 16'h0002);
		$display("modes done");
		repeat (34)
		begin
			a = xr();
			b = xr();
			if (q.size() < 63)
				q = {q, a, b};
			push(a);
			push(b);
		end
		sv <= 1'b0;
		repeat (40) @(posedge ref_clk_i);
		st();
		chk(16'(int_o), 16'h0001);
		w(8'h02, 16'h0003);
		chk({14'h0000, ioe, int_o}, 16'h0002);
		w(8'h02, 16'h0000);
		chk({14'h0000, ioe, int_o}, 16'h0001);
		i_msf_host.rd(8'h60, rv);
		chk(rv, 16'h0000);
		w(8'h5F, 16'h0001);
		w(8'h5F, 16'h0001);
		chk(16'(fre), 16'h0001);
		repeat (2)
		begin
			i_msf_host.rd(8'h60, rv);
			chk(rv, q.pop_front());
		end
		st();
		$display("fifo done");
		w(8'h00, 16'h80FF);
		q.delete();
		st();
		chk(16'(int_o), 16'h0000);
		w(8'h10, 16'h0000);
		chk(16'(mode), 16'h0000);
		w(8'h10, 16'h0001);
		w(8'h4B, 16'h0000);
		w(8'h10, 16'h0000);
		chk(16'(mode), 16'h0001);
		$display("lock done");
		close_out();
	end
endmodule
